// ===== verilog/hsmeb_regs.svh
/*
 * timing constants and bus codes for the high-speed entry/exit bridge.
 * assumes a 50 MHz core clock; all counts derive from the times below.
 */
`ifndef HSMEB_REGS_SVH
`define HSMEB_REGS_SVH

// ==================================================================
// clock rate and conversion of a least time to whole cycles
`define HSMEB_CLK_MHZ 50
`define HSMEB_CYC_MIN(ns) (((((ns) * `HSMEB_CLK_MHZ) + 999) / 1000))

// ==================================================================
// clock phase, setup and recovery times in ns
`define HSMEB_SM_LOW_NS 4700
`define HSMEB_SM_HIGH_NS 4000
`define HSMEB_FM_LOW_NS 1300
`define HSMEB_FM_HIGH_NS 600
`define HSMEB_HS_HIGH_NS 100
`define HSMEB_HS_LOW_NS 200
`define HSMEB_FM_SETUP_NS 600
`define HSMEB_HS_SETUP_NS 160
`define HSMEB_RECOVER_NS 1000

// ==================================================================
// bus codes and bit positions
`define HSMEB_MCODE_TOP 5'h01
`define HSMEB_ACK_SLOT 4'h8
`define HSMEB_CNT_ONE 8'h01
`define HSMEB_CNT_ZERO 8'h00

`endif

// ===== verilog/hsmeb_pkg.sv
/*
 * types and timing functions shared by the bridge modules.
 * assumes hsmeb_regs.svh is on the include path.
 */
`include "hsmeb_regs.svh"

package hsmeb_pkg;

    // ==============================================================
    // types
    typedef logic [7:0] hsmeb_cnt_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_START = 4'h1,
        M_LOW = 4'h2,
        M_HIGH = 4'h3,
        M_TH_LOW = 4'h4,
        M_TH_HIGH = 4'h5,
        M_RSTART = 4'h6,
        M_STOP_LOW = 4'h7,
        M_STOP_HIGH = 4'h8,
        M_LOST = 4'h9
    } hsmeb_mst_e;

    typedef enum logic [2:0] {
        BR_JOIN = 3'h0,
        BR_DOPEN = 3'h1,
        BR_PULL = 3'h2,
        BR_WAITH = 3'h3,
        BR_ISO = 3'h4,
        BR_REL = 3'h5
    } hsmeb_br_e;

    // ==============================================================
    // phase lengths; the high-speed pair keeps high to low at 1 to 2
    function automatic hsmeb_cnt_t hsmeb_low_cyc(input logic hs, input logic std);
        if (hs) begin
            return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_HS_LOW_NS));
        end else if (std) begin
            return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_SM_LOW_NS));
        end
        return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_FM_LOW_NS));
    endfunction : hsmeb_low_cyc

    function automatic hsmeb_cnt_t hsmeb_high_cyc(input logic hs, input logic std);
        if (hs) begin
            return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_HS_HIGH_NS));
        end else if (std) begin
            return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_SM_HIGH_NS));
        end
        return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_FM_HIGH_NS));
    endfunction : hsmeb_high_cyc

    function automatic hsmeb_cnt_t hsmeb_setup_cyc(input logic hs);
        if (hs) begin
            return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_HS_SETUP_NS));
        end
        return hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_FM_SETUP_NS));
    endfunction : hsmeb_setup_cyc

endpackage : hsmeb_pkg

// ===== verilog/hsmeb_ev_if.sv
/*
 * carrier between the bus condition detector and the mode controller.
 * assumes levels are already synchronised to core_clk.
 */
`timescale 1ns/1ps

interface hsmeb_ev_if;
    logic sdah;
    logic sclh;
    logic start_p;
    logic stop_p;
    logic mcode_p;
    logic busy;

    modport det (input sdah, input sclh, output start_p, output stop_p,
                 output mcode_p, output busy);
    modport ctl (output sdah, output sclh, input start_p, input stop_p,
                 input mcode_p, input busy);
endinterface : hsmeb_ev_if

// ===== verilog/hsmeb_cond_det.sv
/*
 * start, stop and high-speed master code detector on the high-speed section.
 * assumes synchronised sdah/sclh levels arrive through the interface.
 */
`timescale 1ns/1ps
`include "hsmeb_regs.svh"

module hsmeb_cond_det
    import hsmeb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    hsmeb_ev_if.det ev
);

    logic sda_prev_q;
    logic scl_prev_q;
    logic busy_q;
    logic first_q;
    logic start_q;
    logic stop_q;
    logic mcode_q;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic start_d;
    logic stop_d;
    logic rise_d;

    // ==============================================================
    // conditions
    assign start_d = ev.sclh && scl_prev_q && sda_prev_q && !ev.sdah;
    assign stop_d = ev.sclh && scl_prev_q && !sda_prev_q && ev.sdah;
    assign rise_d = ev.sclh && !scl_prev_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sda_prev_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= ev.sdah;
            scl_prev_q <= ev.sclh;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            start_q <= start_d;
            stop_q <= stop_d;
            if (stop_d) begin
                busy_q <= 1'b0;
            end else if (start_d) begin
                busy_q <= 1'b1;
            end
        end
    end

    // ==============================================================
    // byte after a first start; nack slot must read released
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            first_q <= 1'b0;
            mcode_q <= 1'b0;
        end else begin
            mcode_q <= 1'b0;
            if (start_d) begin
                bit_q <= 4'h0;
                first_q <= !busy_q;
            end else if (rise_d) begin
                if (bit_q == `HSMEB_ACK_SLOT) begin
                    mcode_q <= first_q && (shift_q[7:3] == `HSMEB_MCODE_TOP) && ev.sdah;
                    first_q <= 1'b0;
                    bit_q <= 4'h0;
                end else begin
                    shift_q <= {shift_q[6:0], ev.sdah};
                    bit_q <= bit_q + 4'h1;
                end
            end
        end
    end

    assign ev.start_p = start_q;
    assign ev.stop_p = stop_q;
    assign ev.mcode_p = mcode_q;
    assign ev.busy = busy_q;

    chk_mcode_nack_slot: assert property (@(posedge core_clk) disable iff (!rst_n)
        mcode_q |-> $past(ev.sdah) && $past(ev.sclh))
        else $error("master code flagged without a released nack slot");

endmodule : hsmeb_cond_det

// ===== verilog/hsmeb_top.sv
/*
 * high-speed mode entry/exit controller, master engine and section bridge.
 * assumes raw pin levels from outside; the bench resolves open-drain wires.
 */
// Function
// - arbitration only during master code and nack
// - master code is never acknowledged
// - winner enables current source after clock high
// - master sends repeated start, address, samples ack
// - current source off after start, ack bits
// - high-speed persists until stop, chaining allowed
// - reset puts every setting into fast mode
// - detect master code and nack, switch settings
// - winner adapts filters, timing, slope, bit rate
// - losing masters switch filters, idle until stop
// - slaves adapt filters, timing, data slope optionally
// - stop restores fast settings within bus free
// - no master code means current source off
// - bridge decides only from observed bus lines
// - bridge joins sections during slow traffic
// - bridge isolates sections during high-speed traffic
// - mixed arbitration only during master code
// - reserved code win keeps bridge closed; the bridge here opens on any master code, reserved or not
// - slow timing limited by slowest device present
// - high-speed clock high to low is 1:2
// - slave stretching only after acknowledge bit
// - slow clock held low reconnects bridge
`timescale 1ns/1ps
`include "hsmeb_regs.svh"

module hsmeb_top
    import hsmeb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sdah_rx,
    output logic sdah_tx,
    output logic sdah_oe,
    input wire logic sclh_rx,
    output logic sclh_tx,
    output logic sclh_oe,
    input wire logic sda_rx,
    input wire logic scl_rx,
    input wire logic go,
    input wire logic [7:0] addr_rw,
    input wire logic chain,
    input wire logic [2:0] mcode_lo,
    input wire logic std_bus,
    input wire logic slave_slope_en,
    output logic done,
    output logic acked,
    output logic arb_lost,
    output logic bus_busy,
    output logic mode_hs,
    output logic filter_hs,
    output logic timing_hs,
    output logic clk_slope_hs,
    output logic data_slope_hs,
    output logic hs_rate,
    output logic clock_current_source_pullup,
    output logic data_section_switch,
    output logic clock_section_switch,
    output logic fs_data_pulldown
);

    hsmeb_ev_if ev ();

    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic sdah_s;
    logic sclh_s;
    logic sda_s;
    logic scl_s;
    hsmeb_mst_e st_q;
    logic mc_seg_q;
    logic [8:0] tx_q;
    logic [3:0] bit_q;
    hsmeb_cnt_t cnt_q;
    logic sda_drv_q;
    logic scl_drv_q;
    logic done_q;
    logic ack_q;
    logic hs_q;
    logic win_q;
    logic hold_q;
    logic mcs_q;
    hsmeb_br_e br_q;
    hsmeb_cnt_t rec_q;
    logic rate_hs;
    logic recover;

    // ==============================================================
    // pin synchronisers; only the second stage is read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q <= 4'hf;
            sync_q <= 4'hf;
        end else begin
            meta_q <= {scl_rx, sda_rx, sclh_rx, sdah_rx};
            sync_q <= meta_q;
        end
    end

    assign sdah_s = sync_q[0];
    assign sclh_s = sync_q[1];
    assign sda_s = sync_q[2];
    assign scl_s = sync_q[3];
    assign ev.sdah = sdah_s;
    assign ev.sclh = sclh_s;

    hsmeb_cond_det u_det (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ev(ev)
    );

    // ==============================================================
    // mode settings, changed only by bus traffic
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hs_q <= 1'b0;
            win_q <= 1'b0;
        end else if (ev.stop_p) begin
            hs_q <= 1'b0;
            win_q <= 1'b0;
        end else if (ev.mcode_p) begin
            hs_q <= 1'b1;
            win_q <= mc_seg_q && (st_q == M_HIGH);
        end
    end

    assign rate_hs = hs_q && win_q;
    assign mode_hs = hs_q;
    assign filter_hs = hs_q;
    assign timing_hs = hs_q && (st_q != M_LOST);
    assign clk_slope_hs = rate_hs;
    assign data_slope_hs = rate_hs || (hs_q && !win_q && slave_slope_en && st_q != M_LOST);
    assign hs_rate = rate_hs;
    assign arb_lost = (st_q == M_LOST);
    assign bus_busy = ev.busy;

    // ==============================================================
    // master engine: start, master code, nack, then high-speed frames
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= M_IDLE;
            mc_seg_q <= 1'b0;
            tx_q <= 9'h1ff;
            bit_q <= 4'h0;
            cnt_q <= `HSMEB_CNT_ZERO;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    if (go && !ev.busy) begin
                        sda_drv_q <= 1'b1;
                        cnt_q <= hsmeb_setup_cyc(1'b0);
                        tx_q <= {`HSMEB_MCODE_TOP, mcode_lo, 1'b1};
                        mc_seg_q <= 1'b1;
                        bit_q <= 4'h0;
                        st_q <= M_START;
                    end
                end
                M_START: begin
                    if (cnt_q == `HSMEB_CNT_ZERO) begin
                        scl_drv_q <= 1'b1;
                        cnt_q <= hsmeb_low_cyc(rate_hs, std_bus);
                        st_q <= M_LOW;
                    end else begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_LOW: begin
                    sda_drv_q <= !tx_q[8];
                    if (cnt_q == `HSMEB_CNT_ZERO) begin
                        scl_drv_q <= 1'b0;
                        cnt_q <= hsmeb_high_cyc(rate_hs, std_bus);
                        st_q <= M_HIGH;
                    end else begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_HIGH: begin
                    // high time counts only once the line is really high
                    if (!sclh_s) begin
                        cnt_q <= cnt_q;
                    end else if (mc_seg_q && !sda_drv_q && !sdah_s) begin
                        sda_drv_q <= 1'b0;
                        st_q <= M_LOST;
                    end else if (cnt_q != `HSMEB_CNT_ZERO) begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end else if (bit_q == `HSMEB_ACK_SLOT) begin
                        scl_drv_q <= 1'b1;
                        bit_q <= 4'h0;
                        cnt_q <= hsmeb_low_cyc(rate_hs, std_bus);
                        if (mc_seg_q) begin
                            sda_drv_q <= 1'b0;
                            st_q <= M_TH_LOW;
                        end else begin
                            ack_q <= !sdah_s;
                            done_q <= 1'b1;
                            sda_drv_q <= !chain;
                            st_q <= chain ? M_TH_LOW : M_STOP_LOW;
                        end
                    end else begin
                        scl_drv_q <= 1'b1;
                        bit_q <= bit_q + 4'h1;
                        tx_q <= {tx_q[7:0], 1'b1};
                        cnt_q <= hsmeb_low_cyc(rate_hs, std_bus);
                        st_q <= M_LOW;
                    end
                end
                M_TH_LOW: begin
                    if (cnt_q == `HSMEB_CNT_ZERO) begin
                        scl_drv_q <= 1'b0;
                        cnt_q <= hsmeb_setup_cyc(rate_hs);
                        st_q <= M_TH_HIGH;
                    end else begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_TH_HIGH: begin
                    if (sclh_s && cnt_q == `HSMEB_CNT_ZERO) begin
                        sda_drv_q <= 1'b1;
                        cnt_q <= hsmeb_setup_cyc(rate_hs);
                        st_q <= M_RSTART;
                    end else if (sclh_s) begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_RSTART: begin
                    if (cnt_q == `HSMEB_CNT_ZERO) begin
                        scl_drv_q <= 1'b1;
                        tx_q <= {addr_rw, 1'b1};
                        mc_seg_q <= 1'b0;
                        cnt_q <= hsmeb_low_cyc(rate_hs, std_bus);
                        st_q <= M_LOW;
                    end else begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_STOP_LOW: begin
                    if (cnt_q == `HSMEB_CNT_ZERO) begin
                        scl_drv_q <= 1'b0;
                        cnt_q <= hsmeb_setup_cyc(rate_hs);
                        st_q <= M_STOP_HIGH;
                    end else begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_STOP_HIGH: begin
                    if (sclh_s && cnt_q == `HSMEB_CNT_ZERO) begin
                        sda_drv_q <= 1'b0;
                        st_q <= M_IDLE;
                    end else if (sclh_s) begin
                        cnt_q <= cnt_q - `HSMEB_CNT_ONE;
                    end
                end
                M_LOST: begin
                    sda_drv_q <= 1'b0;
                    scl_drv_q <= 1'b0;
                    if (ev.stop_p) begin
                        st_q <= M_IDLE;
                    end
                end
                default: begin
                    st_q <= M_IDLE;
                end
            endcase
        end
    end

    assign sdah_tx = 1'b0;
    assign sdah_oe = sda_drv_q;
    assign sclh_tx = 1'b0;
    assign sclh_oe = scl_drv_q;
    assign done = done_q;
    assign acked = ack_q;

    // ==============================================================
    // current source: held off after sr and ack slots so others may stretch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_q <= 1'b1;
        end else if ((st_q == M_RSTART && cnt_q == `HSMEB_CNT_ZERO) ||
                     (st_q == M_HIGH && bit_q == `HSMEB_ACK_SLOT)) begin
            hold_q <= 1'b1;
        end else if (rate_hs && !scl_drv_q && sclh_s) begin
            hold_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mcs_q <= 1'b0;
        end else begin
            mcs_q <= rate_hs && !hold_q && !scl_drv_q && !ev.stop_p;
        end
    end

    assign clock_current_source_pullup = mcs_q;

    // ==============================================================
    // autonomous bridge, steered by the observed lines alone
    assign recover = (rec_q == hsmeb_cnt_t'(`HSMEB_CYC_MIN(`HSMEB_RECOVER_NS)));

    always_ff @(posedge core_clk) begin
        if (!rst_n || br_q != BR_ISO || scl_s) begin
            rec_q <= `HSMEB_CNT_ZERO;
        end else if (!recover) begin
            rec_q <= rec_q + `HSMEB_CNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            br_q <= BR_JOIN;
        end else if (recover) begin
            br_q <= BR_JOIN;
        end else begin
            case (br_q)
                BR_JOIN: begin
                    if (ev.mcode_p) begin
                        br_q <= BR_DOPEN;
                    end
                end
                BR_DOPEN: begin
                    br_q <= ev.stop_p ? BR_REL : BR_PULL;
                end
                BR_PULL: begin
                    if (ev.stop_p) begin
                        br_q <= BR_REL;
                    end else if (!sclh_s) begin
                        br_q <= BR_WAITH;
                    end
                end
                BR_WAITH: begin
                    if (ev.stop_p) begin
                        br_q <= BR_REL;
                    end else if (sclh_s && scl_s) begin
                        br_q <= BR_ISO;
                    end
                end
                BR_ISO: begin
                    if (ev.stop_p) begin
                        br_q <= BR_REL;
                    end
                end
                BR_REL: begin
                    // data rejoins only once sda_s reads high to avoid spikes
                    if (sda_s) begin
                        br_q <= BR_JOIN;
                    end
                end
                default: begin
                    br_q <= BR_JOIN;
                end
            endcase
        end
    end

    assign data_section_switch = (br_q == BR_JOIN);
    assign clock_section_switch = (br_q != BR_ISO);
    assign fs_data_pulldown = (br_q == BR_PULL) || (br_q == BR_WAITH) || (br_q == BR_ISO);

    // ==============================================================
    // checks
    chk_reset_fast_mode: assert property (@(posedge core_clk)
        !rst_n |=> !mode_hs && !clock_current_source_pullup && data_section_switch)
        else $error("reset did not leave fast mode settings");

    chk_mcode_enters_hs: assert property (@(posedge core_clk) disable iff (!rst_n)
        ev.mcode_p && !ev.stop_p |=> mode_hs && filter_hs)
        else $error("master code did not switch to high-speed settings");

    chk_stop_restores: assert property (@(posedge core_clk) disable iff (!rst_n)
        ev.stop_p |=> !mode_hs && !clock_current_source_pullup)
        else $error("stop did not restore fast mode");

    chk_source_needs_win: assert property (@(posedge core_clk) disable iff (!rst_n)
        clock_current_source_pullup |-> $past(hs_q) && $past(win_q))
        else $error("current source on outside a won high-speed frame");

    chk_source_off_sr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == M_RSTART && cnt_q == `HSMEB_CNT_ZERO) |-> ##3 !clock_current_source_pullup)
        else $error("current source still on after repeated start");

    chk_isolate_pulls: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clock_section_switch |-> !data_section_switch && fs_data_pulldown)
        else $error("clock section open without data isolation");

    chk_join_when_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (br_q == BR_JOIN && !ev.mcode_p) |=> data_section_switch && clock_section_switch)
        else $error("bridge opened without a master code");

    chk_recover_join: assert property (@(posedge core_clk) disable iff (!rst_n)
        recover |=> data_section_switch && clock_section_switch && !fs_data_pulldown)
        else $error("held slow clock did not reconnect the bridge");

    chk_lost_released: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == M_LOST) |=> !sclh_oe && !sdah_oe)
        else $error("losing master still drives the bus");

    chk_arb_mcode_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(st_q == M_LOST) |-> $past(mc_seg_q))
        else $error("arbitration lost outside the master code");

endmodule : hsmeb_top

// ===== sim/hsmeb_slave_model.sv
/*
 * slave model on the high-speed section: acks address bytes after Sr.
 * assumes resolved open-drain wire levels as inputs.
 */
`timescale 1ns/1ps
module hsmeb_slave_model (
    input wire logic sdah,
    input wire logic sclh,
    input wire logic ack_en,
    output logic sda_pull
);
    int cnt = 0;
    logic busy = 1'b0;
    logic first = 1'b0;
    initial sda_pull = 1'b0;
    // ==============================================================
    // start, repeated start and stop seen on the wires
    always @(negedge sdah) begin
        if (sclh) begin
            first = !busy;
            busy = 1'b1;
            cnt = 0;
        end
    end
    always @(posedge sdah) begin
        if (sclh) begin
            busy = 1'b0;
        end
    end
    // master code never acked pull only in slot 9, no stretching
    always @(negedge sclh) begin
        cnt = cnt + 1;
        sda_pull = (cnt == 9) && !first && ack_en && busy;
    end
endmodule : hsmeb_slave_model

// ===== sim/hsmeb_top_tb.sv
/*
 * self-checking bench: high-speed frames with ack, nack and chaining.
 * assumes open-drain wires resolved here; f/s lines follow the bridge.
 */
`timescale 1ns/1ps
module hsmeb_top_tb;
    import hsmeb_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic chain = 1'b0;
    logic ack_en = 1'b1;
    logic sdah_oe, sclh_oe, pull, done, acked, bus_busy, mode_hs, hs_rate, pu;
    logic dsw, csw, fpd;
    logic fhs, ths, cshs, dshs, lost, dtx, ctx;
    int num_errors = 0;
    int n_compared = 0;
    wire sdah = !(sdah_oe | pull);
    wire sclh = !sclh_oe;
    always #10 core_clk = !core_clk;
    hsmeb_top u_hsmeb_top (.core_clk(core_clk), .rst_n(rst_n), .sdah_rx(sdah), .sdah_tx(dtx),
        .sdah_oe(sdah_oe), .sclh_rx(sclh), .sclh_tx(ctx), .sclh_oe(sclh_oe),
        .sda_rx(dsw ? sdah : !fpd), .scl_rx(csw ? sclh : 1'b1), .go(go),
        .addr_rw(8'ha4), .chain(chain), .mcode_lo(3'h5), .std_bus(1'b0),
        .slave_slope_en(1'b0), .done(done), .acked(acked), .arb_lost(lost), .bus_busy(bus_busy),
        .mode_hs(mode_hs), .filter_hs(fhs), .timing_hs(ths), .clk_slope_hs(cshs),
        .data_slope_hs(dshs),
        .hs_rate(hs_rate), .clock_current_source_pullup(pu), .data_section_switch(dsw),
        .clock_section_switch(csw), .fs_data_pulldown(fpd));
    hsmeb_slave_model u_hsmeb_slave_model (.sdah(sdah), .sclh(sclh), .ack_en(ack_en),
        .sda_pull(pull));
    // ==============================================================
    // shared tasks
    task automatic end_of_test;
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(string what, logic seen, logic exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    // bounded wait; done pulse is looked at in its own cycle
    task automatic wait_done;
        int i;
        for (i = 0; i < 20000 && done !== 1'b1; i++) @(posedge core_clk) #2;
        if (i == 20000) begin num_errors++; end_of_test(); end
    endtask : wait_done
    task automatic wait_idle;
        int i;
        for (i = 0; i < 20000 && !(bus_busy === 1'b0 && dsw === 1'b1); i++)
            @(posedge core_clk) #2;
        if (i == 20000) begin num_errors++; end_of_test(); end
        repeat (20) @(posedge core_clk);
        #2;
    endtask : wait_idle
    task automatic run_frame(logic ack, logic chn);
        ack_en = ack;
        chain = chn;
        go = 1'b1;
        @(posedge core_clk) #2;
        go = 1'b0;
        wait_done();
    endtask : run_frame
    task automatic check_fast;
        check("mode_hs", mode_hs, 1'b0);
        check("pullup", pu, 1'b0);
        check("data_sw", dsw, 1'b1);
        check("clock_sw", csw, 1'b1);
        check("pulldown", fpd, 1'b0);
        check("filter_hs", fhs, 1'b0);
        check("timing_hs", ths, 1'b0);
        check("arb_lost", lost, 1'b0);
        check("sdah_tx", dtx, 1'b0);
        check("sclh_tx", ctx, 1'b0);
    endtask : check_fast
    // ==============================================================
    // scenarios
    task automatic t_hs_ack;
        run_frame(1'b1, 1'b0);
        check("acked", acked, 1'b1);
        check("mode_hs", mode_hs, 1'b1);
        check("hs_rate", hs_rate, 1'b1);
        check("filter_hs", fhs, 1'b1);
        check("timing_hs", ths, 1'b1);
        check("clk_slope", cshs, 1'b1);
        check("data_slope", dshs, 1'b1);
        check("arb_lost", lost, 1'b0);
        check("data_sw", dsw, 1'b0);
        check("clock_sw", csw, 1'b0);
        wait_idle();
        check_fast();
    endtask : t_hs_ack
    task automatic t_nack;
        run_frame(1'b0, 1'b0);
        check("acked", acked, 1'b0);
        wait_idle();
        check("mode_hs", mode_hs, 1'b0);
    endtask : t_nack
    task automatic t_chain;
        run_frame(1'b1, 1'b1);
        @(posedge core_clk) #2;
        wait_done();
        check("mode_hs", mode_hs, 1'b1);
        check("clock_sw", csw, 1'b0);
        chain = 1'b0;
        @(posedge core_clk) #2;
        wait_done();
        wait_idle();
        check_fast();
    endtask : t_chain
    initial begin
        repeat (16) @(posedge core_clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #2;
        check_fast();
        t_hs_ack();
        t_nack();
        t_chain();
        end_of_test();
    end
endmodule : hsmeb_top_tb
